// >>> rtl/adc_ctrl_pkg.sv
// constants and types for the converter control block
package adc_ctrl_pkg;
    localparam logic [15:0] CFG_ADDR       = 16'hD004;
    localparam logic [15:0] OFFSET_ADDR    = 16'hD008;
    localparam logic [15:0] GAIN_ADDR      = 16'hD00C;
    localparam logic [15:0] DMACFG_ADDR    = 16'hD010;
    localparam logic [15:0] DMASTAT_ADDR   = 16'hD014;
    localparam logic [15:0] BUF_START_ADDR = 16'hD018;
    localparam logic [15:0] BUF_LEN_ADDR   = 16'hD01C;
    localparam logic [15:0] DMACUR_ADDR    = 16'hD020;
    localparam logic [15:0] FLAGS_ADDR     = 16'hD024;
    localparam logic [15:0] MASK_ADDR      = 16'hD028;
    localparam logic [15:0] CFG_RESET      = 16'h1800;
    localparam logic [15:0] CFG_WRITABLE   = 16'hFFFD;
    localparam logic [15:0] OFFSET_RESET   = 16'h0000;
    localparam logic [15:0] GAIN_RESET     = 16'h8000;
    localparam int DMA_LAUNCH_BIT = 0;
    localparam int DMA_WRAP_BIT   = 1;
    localparam int DMA_RESET_BIT  = 4;
    localparam int FLAG_OVF  = 0;
    localparam int FLAG_SAT  = 1;
    localparam int FLAG_FULL = 2;
    localparam int FLAG_HALF = 3;
    localparam logic [3:0] SEL_PIN_LAST = 4'h5;
    localparam logic [3:0] SEL_GND      = 4'h8;
    localparam logic [3:0] SEL_HALF_REG = 4'hB;
    localparam int PCLK_HZ        = 40000000;
    localparam int FAST_SAMPLE_HZ = 6000000;
    localparam int SLOW_SAMPLE_HZ = 1000000;
    localparam int STARTUP_US     = 21;
    localparam int STARTUP_CYCLES = (STARTUP_US * PCLK_HZ + 999999) / 1000000;
    localparam logic [5:0] PHASE_MOD  = 6'(PCLK_HZ / SLOW_SAMPLE_HZ);
    localparam logic [5:0] FAST_STEP  = 6'(FAST_SAMPLE_HZ / SLOW_SAMPLE_HZ);
    localparam logic [5:0] SLOW_STEP  = 6'h01;
    localparam logic [12:0] BASE_CLOCKS = 13'h0020;
    localparam logic [3:0]  BASE_BITS   = 4'h5;

    typedef struct packed {
        logic [2:0] period;
        logic       pos_buf;
        logic       neg_buf;
        logic [3:0] pos_sel;
        logic [3:0] neg_sel;
        logic       slow_clk;
        logic       rsvd;
        logic       run;
    } cfg_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } dma_write_type;

    typedef enum logic [1:0] {CONV_IDLE, CONV_STARTUP, CONV_DISCARD, CONV_OUTPUT} adc_state_type;
endpackage

// >>> rtl/adc_input_timing_control.sv
// converter input, timing, correction and sample dma control
// What this block does
// - 4-bit select per input: 0-5 pins, 8 gnd, 9 half ref, 10 ref, 11 half reg
// - separate wide-range bits enable quarter-gain buffer per input
// - sampling clock 6 MHz with slow select clear, 1 MHz when set
// - sampling clocks per conversion are 32 times two to the code
// - results 16 bits, left aligned, five plus code significant bits
// - sample timing identical on crystal or rc oscillator
// - run bit set gives back-to-back conversions until cleared
// - enable from disabled adds 21 us startup delay before conversions
// - first conversion after enable or setup change is discarded
// - processor oscillator switch discards one conversion, without a new startup delay
// - setup change while dma active does not stop the dma, unless it clears run
// - add signed offset, multiply by 1.15 gain, saturate and flag
// - auto-wrap dma restarts at start until disabled or reset
// - sample-length code sits in setup bits 15 to 13
`timescale 1ns/1ps
module adc_input_timing_control #(
    parameter int LEN_W = 14
) (
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [15:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // analog front end
    output logic      [3:0]                  pos_input_select,
    output logic      [3:0]                  neg_input_select,
    output logic                             pos_input_connected,
    output logic                             neg_input_connected,
    output logic                             pos_wide_range_buffer,
    output logic                             neg_wide_range_buffer,
    output logic                             sample_clock_en,
    output logic                             converter_active,
    input  wire logic                        modulator_bit,
    // system clock source
    input  wire logic                        osc_is_rc,
    // sample dma write port
    output adc_ctrl_pkg::dma_write_type      dma_write,
    output logic                             dma_write_valid
);
    import adc_ctrl_pkg::*;

    cfg_type       cfg;
    adc_state_type state;
    logic [15:0]   offset;
    logic [15:0]   gain;
    logic [15:0]   buf_start;
    logic [LEN_W-1:0] buf_len;
    logic [LEN_W-1:0] dma_ptr;
    logic          dma_active;
    logic          dma_wrap;
    logic [3:0]    flags;
    logic [3:0]    converter_event_mask;
    logic [5:0]    phase;
    logic [12:0]   clk_count;
    logic [12:0]   ones;
    logic [9:0]    wait_count;
    logic          osc_prev;
    logic          tick;
    logic          restart;
    logic          cfg_changed;
    logic          conv_done;
    logic          result_valid;
    logic          wr;
    logic          rd_setup;
    logic          dmacfg_wr;
    logic          mapped;
    logic [12:0]   conv_len;
    logic [16:0]   corrected;
    logic [15:0]   raw;
    logic [31:0]   rd_value;
    logic [3:0]    flag_set;

    function automatic logic input_connected(input logic [3:0] code);
        return (code <= SEL_PIN_LAST) || (code >= SEL_GND && code <= SEL_HALF_REG);
    endfunction

    // ones over the window, left aligned and offset to two's complement
    function automatic logic [15:0] left_align(input logic [12:0] n, input logic [2:0] code);
        logic [16:0] wide;
        wide = 17'(n) << (4'hB - 4'(code));
        if (wide[16])
            wide = 17'h0FFFF;
        return wide[15:0] ^ 16'h8000;
    endfunction

    // returns {saturated, value}
    function automatic logic [16:0] correct(input logic [15:0] r, input logic [15:0] o,
                                            input logic [15:0] g);
        logic signed [16:0] sum;
        logic signed [33:0] prod;
        logic signed [33:0] scaled;
        sum = 17'(signed'(r)) + 17'(signed'(o));
        prod = 34'(sum) * 34'(signed'({1'b0, g}));
        scaled = prod >>> 15;
        if (scaled > 34'sh07FFF)
            return {1'b1, 16'h7FFF};
        else if (scaled < -34'sh08000)
            return {1'b1, 16'h8000};
        return {1'b0, scaled[15:0]};
    endfunction

    // apb decode; zero wait states, read data captured in the setup cycle
    assign wr        = psel && penable && pwrite;
    assign rd_setup  = psel && !penable && !pwrite;
    assign dmacfg_wr = wr && paddr == DMACFG_ADDR;
    assign pready    = 1'b1;

    always_comb begin
        mapped = 1'b1;
        case (paddr)
            CFG_ADDR:       rd_value = {16'h0000, cfg};
            OFFSET_ADDR:    rd_value = {16'h0000, offset};
            GAIN_ADDR:      rd_value = {16'h0000, gain};
            DMACFG_ADDR:    rd_value = {30'h0, dma_wrap, 1'b0};
            DMASTAT_ADDR:   rd_value = {31'h0, dma_active};
            BUF_START_ADDR: rd_value = {16'h0000, buf_start};
            BUF_LEN_ADDR:   rd_value = 32'(buf_len);
            DMACUR_ADDR:    rd_value = {16'h0000, 16'(buf_start + 16'({dma_ptr, 1'b0}))};
            FLAGS_ADDR:     rd_value = {28'h0, flags};
            MASK_ADDR:      rd_value = {28'h0, converter_event_mask};
            default: begin
                rd_value = 32'h0;
                mapped   = 1'b0;
            end
        endcase
    end

    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0;
        else if (rd_setup)
            prdata <= rd_value;
    end

    // setup register; bit 1 is forced to zero
    assign cfg_changed = wr && paddr == CFG_ADDR && cfg.run &&
                         ((pwdata[15:0] & CFG_WRITABLE) != cfg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg                  <= CFG_RESET;
            offset               <= OFFSET_RESET;
            gain                 <= GAIN_RESET;
            buf_start            <= 16'h0000;
            buf_len              <= '0;
            converter_event_mask <= 4'h0;
        end else if (wr) begin
            case (paddr)
                CFG_ADDR:       cfg <= pwdata[15:0] & CFG_WRITABLE;
                OFFSET_ADDR:    offset <= pwdata[15:0];
                GAIN_ADDR:      gain <= pwdata[15:0];
                BUF_START_ADDR: buf_start <= {pwdata[15:1], 1'b0};
                BUF_LEN_ADDR:   buf_len <= pwdata[LEN_W-1:0];
                MASK_ADDR:      converter_event_mask <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // analog selections follow the setup register directly
    assign pos_input_select      = cfg.pos_sel;
    assign neg_input_select      = cfg.neg_sel;
    assign pos_input_connected   = input_connected(cfg.pos_sel);
    assign neg_input_connected   = input_connected(cfg.neg_sel);
    assign pos_wide_range_buffer = cfg.pos_buf;
    assign neg_wide_range_buffer = cfg.neg_buf;
    assign converter_active      = state != CONV_IDLE;

    // fractional divider: average rate is exact, jitter is one pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 6'h00;
            tick  <= 1'b0;
        end else if (phase + (cfg.slow_clk ? SLOW_STEP : FAST_STEP) >= PHASE_MOD) begin
            phase <= 6'(phase + (cfg.slow_clk ? SLOW_STEP : FAST_STEP) - PHASE_MOD);
            tick  <= 1'b1;
        end else begin
            phase <= 6'(phase + (cfg.slow_clk ? SLOW_STEP : FAST_STEP));
            tick  <= 1'b0;
        end
    end

    assign sample_clock_en = tick && converter_active;

    // pclk stays fixed when the oscillator changes, so only the switch matters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            osc_prev <= 1'b0;
        else
            osc_prev <= osc_is_rc;
    end

    assign restart   = cfg_changed || (osc_prev != osc_is_rc);
    assign conv_len  = BASE_CLOCKS << cfg.period;
    assign conv_done = (state == CONV_DISCARD || state == CONV_OUTPUT) && tick && !restart &&
                       clk_count == 13'(conv_len - 13'h0001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= CONV_IDLE;
            wait_count <= 10'h000;
        end else if (!cfg.run) begin
            state <= CONV_IDLE;
        end else begin
            case (state)
                CONV_IDLE: begin
                    state      <= CONV_STARTUP;
                    wait_count <= 10'h000;
                end
                CONV_STARTUP: begin
                    wait_count <= 10'(wait_count + 10'h001);
                    if (wait_count == 10'(STARTUP_CYCLES - 1))
                        state <= CONV_DISCARD;
                end
                CONV_DISCARD: begin
                    if (conv_done)
                        state <= CONV_OUTPUT;
                end
                CONV_OUTPUT: begin
                    if (restart)
                        state <= CONV_DISCARD;
                end
                default: state <= CONV_IDLE;
            endcase
        end
    end

    // sample window counter and modulator ones count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_count <= 13'h0000;
            ones      <= 13'h0000;
        end else if (restart || !(state == CONV_DISCARD || state == CONV_OUTPUT)) begin
            clk_count <= 13'h0000;
            ones      <= 13'h0000;
        end else if (conv_done) begin
            clk_count <= 13'h0000;
            ones      <= 13'h0000;
        end else if (tick) begin
            clk_count <= 13'(clk_count + 13'h0001);
            ones      <= 13'(ones + 13'(modulator_bit));
        end
    end

    assign result_valid = conv_done && state == CONV_OUTPUT;
    assign raw          = left_align(13'(ones + 13'(modulator_bit)), cfg.period);
    assign corrected    = correct(raw, offset, gain);

    // sample dma; setup writes leave it alone unless they clear run, which stops it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_active <= 1'b0;
            dma_wrap   <= 1'b0;
            dma_ptr    <= '0;
        end else if (dmacfg_wr && pwdata[DMA_RESET_BIT]) begin
            dma_active <= 1'b0;
            dma_ptr    <= '0;
        end else if (dmacfg_wr && pwdata[DMA_LAUNCH_BIT]) begin
            dma_active <= 1'b1;
            dma_wrap   <= pwdata[DMA_WRAP_BIT];
            dma_ptr    <= '0;
        end else if (!cfg.run) begin
            dma_active <= 1'b0;
        end else if (result_valid && dma_active) begin
            if (dma_ptr == LEN_W'(buf_len - 1'b1)) begin
                dma_ptr    <= '0;
                dma_active <= dma_wrap;
            end else begin
                dma_ptr <= LEN_W'(dma_ptr + 1'b1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_write       <= '0;
            dma_write_valid <= 1'b0;
        end else begin
            dma_write_valid <= result_valid && dma_active;
            if (result_valid && dma_active) begin
                dma_write.addr <= 16'(buf_start + 16'({dma_ptr, 1'b0}));
                dma_write.data <= corrected[15:0];
            end
        end
    end

    // sticky events, write one to clear; a new event beats the clear
    always_comb begin
        flag_set            = 4'h0;
        flag_set[FLAG_SAT]  = result_valid && corrected[16];
        flag_set[FLAG_OVF]  = result_valid && !dma_active;
        flag_set[FLAG_FULL] = result_valid && dma_active && dma_ptr == LEN_W'(buf_len - 1'b1);
        flag_set[FLAG_HALF] = result_valid && dma_active &&
                              dma_ptr == LEN_W'((buf_len >> 1) - 1'b1);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            flags <= 4'h0;
        else if (wr && paddr == FLAGS_ADDR)
            flags <= (flags & ~pwdata[3:0]) | flag_set;
        else
            flags <= flags | flag_set;
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_idle_when_off: assert property (!cfg.run |=> state == CONV_IDLE)
        else $error("converter not idle after run cleared");
    a_startup_delay: assert property ($rose(state == CONV_STARTUP) |->
        (state == CONV_STARTUP && wait_count < 10'(STARTUP_CYCLES))[*8])
        else $error("startup delay cut short");
    a_startup_end: assert property (state == CONV_STARTUP && cfg.run &&
        wait_count == 10'(STARTUP_CYCLES - 1) |=> state == CONV_DISCARD)
        else $error("startup did not end in discard");
    a_discard_first: assert property (state == CONV_DISCARD && conv_done |=> !dma_write_valid)
        else $error("discarded conversion was output");
    a_restart_discard: assert property (cfg.run && restart && state == CONV_OUTPUT |=>
        state == CONV_DISCARD)
        else $error("restart did not force a discard");
    a_tick_spacing: assert property (tick |=> !tick)
        else $error("sample clock faster than allowed");
    a_dma_kept: assert property (dma_active && cfg_changed && !dmacfg_wr &&
        !result_valid |=> dma_active)
        else $error("setup change stopped the dma");
    a_wrap_restart: assert property (result_valid && dma_active && dma_wrap && !wr &&
        dma_ptr == LEN_W'(buf_len - 1'b1) |=> dma_ptr == '0 && dma_active)
        else $error("auto-wrap did not restart at buffer start");
    a_sat_flag: assert property (result_valid && corrected[16] |=> flags[FLAG_SAT])
        else $error("saturation not flagged");
    a_dma_data: assert property (result_valid && dma_active |=>
        dma_write_valid && dma_write.data == $past(corrected[15:0]))
        else $error("dma data is not the corrected result");
endmodule // adc_input_timing_control

// >>> tb/adc_modulator_model.sv
// behavioural modulator standing behind the converter inputs
`timescale 1ns/1ps
module adc_modulator_model (
    // clock
    input  wire logic pclk,
    // from the control block
    input  wire logic sample_clock_en,
    input  wire logic converter_active,
    // bench control
    input  wire logic level,
    // to the control block
    output logic      modulator_bit
);
    initial modulator_bit = 1'b0;
    // stopped modulator gives no stream, so the line wanders instead of holding
    always_ff @(posedge pclk) begin
        if (!converter_active)
            modulator_bit <= ~modulator_bit;
        else if (sample_clock_en)
            modulator_bit <= level;
    end
endmodule // adc_modulator_model

// >>> tb/adc_input_timing_control_test.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_input_timing_control_test;
    import adc_ctrl_pkg::*;
    logic          pclk, presetn, psel, penable, pwrite, osc_is_rc, level, err;
    logic [15:0]   paddr, exp_val;
    logic [31:0]   pwdata, prdata, q, seed, v;
    logic          pready, pslverr, pos_con, neg_con, pos_buf, neg_buf;
    logic [3:0]    pos_sel, neg_sel;
    logic          sclk_en, active, mod_bit, dma_valid, dma_on, exp_ok, sat;
    dma_write_type dma_write;
    int            errors, cmp_count, cyc, res_n, res_t, ptr, blen, t, w, n, off, gain, p;
    int            n_gnd, n_ref, n_half;

    adc_input_timing_control #(.LEN_W(14)) u_adc_input_timing_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pos_input_select(pos_sel), .neg_input_select(neg_sel), .pos_input_connected(pos_con),
        .neg_input_connected(neg_con), .pos_wide_range_buffer(pos_buf), .neg_wide_range_buffer(neg_buf),
        .sample_clock_en(sclk_en), .converter_active(active), .modulator_bit(mod_bit),
        .osc_is_rc(osc_is_rc), .dma_write(dma_write), .dma_write_valid(dma_valid));

    adc_modulator_model u_adc_modulator_model (
        .pclk(pclk), .sample_clock_en(sclk_en), .converter_active(active), .level(level),
        .modulator_bit(mod_bit));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic conn(input int c);
        return c < 6 || (c > 7 && c < 12);
    endfunction

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk_near(input string name, input int e, input int g, input int tol);
        cmp_count++;
        if (g < e - tol || g > e + tol) begin
            errors++;
            $display("BAD %s expected %0d seen %0d", name, e, g);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic timeout();
        errors++;
        $display("BAD wait limit expected done seen hang");
        finish_test();
    endtask

    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) timeout();
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // marks the commit edge as the start of a timed span
    task automatic wr_mark(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        #1;
        t = cyc;
    endtask

    task automatic rd(input string name, input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(name, e, q);
    endtask

    task automatic wait_res(input int k);
        int i;
        for (i = 0; i < 12000; i++) begin
            @(posedge pclk);
            #1;
            if (res_n >= k) break;
        end
        if (i == 12000) timeout();
    endtask

    task automatic gap(input string name, input int e, input int tol);
        wait_res(res_n + 1);
        chk_near(name, e, res_t - t, tol);
        t = res_t;
    endtask

    // 400 cycles is 10 us of sampling
    task automatic rate(input int e);
        n = 0;
        repeat (400) begin
            @(posedge pclk);
            if (sclk_en === 1'b1) n++;
        end
        chk_near("sampling ticks", e, n, 1);
    endtask

    // model of the sample dma: every write is checked here, its data only while exp_ok is set
    always @(posedge pclk) begin
        cyc++;
        if (dma_valid === 1'b1) begin
            res_n++;
            res_t = cyc;
            if (exp_ok) chk("dma data", 32'(exp_val), 32'(dma_write.data));
            if (dma_on) begin
                chk("dma address", 32'(16'h2000 + 16'(2 * ptr)), 32'(dma_write.addr));
                ptr = (ptr + 1) % blen;
            end else
                chk("write while dma stopped", 32'h0, 32'h1);
        end
    end

    initial begin
        {psel, penable, pwrite, presetn, osc_is_rc, dma_on, exp_ok} = 7'h00;
        paddr = 16'h0000;
        pwdata = 32'h0;
        level = 1'b1;
        seed = 32'hFA9ACF1B;
        {errors, cmp_count, cyc, res_n, ptr} = {5{32'sd0}};
        blen = 1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd("setup reset", CFG_ADDR, 32'(CFG_RESET));
        rd("offset reset", OFFSET_ADDR, 32'(OFFSET_RESET));
        rd("gain reset", GAIN_ADDR, 32'(GAIN_RESET));
        chk("wide range reset", 32'h3, 32'({pos_buf, neg_buf}));
        rd("unmapped read", 16'hD030, 32'h0);
        chk("unmapped error", 32'h1, 32'(err));
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            v = {16'h0, seed[15:11], 4'(i), 4'(15 - i), seed[2:1], 1'b0};
            wr(CFG_ADDR, v);
            #1;
            chk("positive select", 32'(i), 32'(pos_sel));
            chk("negative select", 32'(15 - i), 32'(neg_sel));
            chk("inputs connected", 32'({conn(i), conn(15 - i)}), 32'({pos_con, neg_con}));
            chk("wide range bits", 32'(v[12:11]), 32'({pos_buf, neg_buf}));
            rd("setup readback", CFG_ADDR, v & 32'(CFG_WRITABLE));
        end
        // calibration from ground and reference readings, each up to 2048 off nominal
        seed = lfsr(seed);
        n_gnd = int'(16'shE000) + int'(seed[11:0]) - 2048;
        n_ref = int'(16'sh2000) + int'(seed[27:16]) - 2048;
        gain = 32'sh8000 * (n_ref - n_gnd) / 32'sh4000;
        off = (n_gnd - int'(16'shE000)) / 2;
        // full-scale input keeps the sum positive, so rounding of the shift is moot
        p = ((32767 + off) * gain) >>> 15;
        sat = p > 32767;
        exp_val = sat ? 16'h7FFF : 16'(p);
        wr(MASK_ADDR, 32'h0);
        wr(DMACFG_ADDR, 32'h10);
        wr(BUF_START_ADDR, 32'h2000);
        wr(BUF_LEN_ADDR, 32'h3);
        wr(OFFSET_ADDR, 32'(16'(off)));
        wr(GAIN_ADDR, 32'(gain));
        {exp_ok, blen, ptr} = {1'b1, 32'sd3, 32'sd0};
        wr_mark(CFG_ADDR, 32'h1);
        wr(FLAGS_ADDR, 32'hF);
        wr(DMACFG_ADDR, 32'h3);
        dma_on = 1'b1;
        w = 32 * 40 / 6;
        gap("first result delay", STARTUP_CYCLES + 2 * w, 16);
        gap("result spacing", w, 3);
        gap("result spacing", w, 3);
        rd("flags after last slot", FLAGS_ADDR, 32'hC | (32'(sat) << 1));
        rate(60);
        w = 64 * 40 / 6;
        wr_mark(CFG_ADDR, 32'h2009);
        gap("discard after change", 2 * w, 16);
        gap("result spacing", w, 3);
        rd("dma kept running", DMASTAT_ADDR, 32'h1);
        @(posedge pclk);
        osc_is_rc <= 1'b1;
        #1;
        t = cyc;
        gap("discard after clock switch", 2 * w, 16);
        gap("spacing on rc clock", w, 3);
        rate(60);
        exp_ok = 1'b0;
        level <= 1'b0;
        // buffered calibration from reference and half-reference readings
        seed = lfsr(seed);
        n_ref = int'(16'shF000);
        n_half = int'(16'shE800) + int'(seed[7:0]) - 128;
        gain = 32'sh8000 * (n_ref - n_half) / 32'sh2000 / 4;
        off = (n_half - int'(16'shE800)) / 2;
        exp_val = 16'(((off - 32768) * gain) >>> 15);
        wr(OFFSET_ADDR, 32'(16'(off)));
        wr(GAIN_ADDR, 32'(gain));
        w = 32 * 40;
        wr_mark(CFG_ADDR, 32'h1805);
        // 1 MHz tick phase is free, so the first tick lands anywhere in one period
        gap("slow first result", 2 * w - 19, 20);
        exp_ok = 1'b1;
        gap("slow spacing", w, 3);
        rate(10);
        wr(FLAGS_ADDR, 32'hF);
        wr(DMACFG_ADDR, 32'h10);
        dma_on = 1'b0;
        rd("dma stopped", DMASTAT_ADDR, 32'h0);
        // a stopped dma gives no write strobe, so poll the flag for the next result
        q = 32'h0;
        for (n = 0; n < 600 && q[0] !== 1'b1; n++)
            apb(1'b0, FLAGS_ADDR, 32'h0);
        if (n == 600) timeout();
        chk("overflow flag", 32'h1, 32'(q[0]));
        // relaunch, so that clearing run has a running dma to stop
        wr(DMACFG_ADDR, 32'h3);
        ptr = 0;
        dma_on = 1'b1;
        wr(CFG_ADDR, 32'h0);
        repeat (3) @(posedge pclk);
        chk("converter stopped", 32'h0, 32'(active));
        rd("dma stopped with converter", DMASTAT_ADDR, 32'h0);
        n = res_n;
        repeat (3000) @(posedge pclk);
        chk("results after stop", 32'(n), 32'(res_n));
        finish_test();
    end
endmodule // adc_input_timing_control_test
